// ### design/sctc_pkg.sv
// Package with the split capture timer register map, field positions and timing counts
package sctc_pkg;
   // Special-function register addresses
   localparam logic [7:0] ADDR_CTRL = 8'hc8;
   localparam logic [7:0] ADDR_RELOAD_LOW = 8'hca;
   localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hcb;
   localparam logic [7:0] ADDR_COUNT_LOW = 8'hcc;
   localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd;

   // Control register field positions
   localparam int BIT_HIGH_OVF = 7;
   localparam int BIT_LOW_OVF = 6;
   localparam int BIT_LOW_IRQ_EN = 5;
   localparam int BIT_CAPTURE_EN = 4;
   localparam int BIT_SPLIT = 3;
   localparam int BIT_RUN = 2;
   localparam int BIT_SRC_SEL = 1;
   localparam int BIT_EXT_CLK = 0;

   // Reset values and the count byte maximum
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [7:0] BYTE_MAX = 8'hff;

   // System clock prescaler for the divide-by-twelve count source
   localparam int PRESCALE_DIV = 12;
   localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE_DIV - 1);

   // Timer state: control, reload pair, count pair
   typedef struct packed {
      logic [7:0] ctl;
      logic [7:0] rll;
      logic [7:0] rlh;
      logic [7:0] cntl;
      logic [7:0] cnth;
   } sctc_state_s;

   // Event generator state: prescaler and slow oscillator synchroniser
   typedef struct packed {
      logic [3:0] div;
      logic sync1;
      logic sync2;
      logic prev;
   } sctc_evt_state_s;
endpackage

// ### design/sctc_evt_if.sv
// Interface between the event generator and the timer core
`timescale 1ns/1ps
interface sctc_evt_if;
   logic tick12;
   logic cap_event;
   logic src_sel;
   logic osc_fall;

   modport src (output tick12, output cap_event, output osc_fall, input src_sel);
   modport snk (input tick12, input cap_event, input osc_fall, output src_sel);
endinterface

// ### design/sctc_event_gen.sv
// Prescale tick and capture event source for the split capture timer
`timescale 1ns/1ps
module sctc_event_gen (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Event sources
   input wire logic sof_pulse,
   input wire logic slow_oscillator,
   // Timer core side
   sctc_evt_if.src evt
);
   sctc_pkg::sctc_evt_state_s s_q, s_d;
   logic fall;

   always_comb begin
      s_d = s_q;
      s_d.div = (s_q.div == sctc_pkg::PRESCALE_LAST) ? 4'h0 : s_q.div + 4'h1;
      s_d.sync1 = slow_oscillator;
      s_d.sync2 = s_q.sync1;
      s_d.prev = s_q.sync2;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Falling edge seen only after the second synchroniser stage
   assign fall = s_q.prev & ~s_q.sync2;
   assign evt.osc_fall = fall;
   assign evt.tick12 = (s_q.div == sctc_pkg::PRESCALE_LAST);
   assign evt.cap_event = evt.src_sel ? fall : sof_pulse; // [RULE_06]
endmodule // sctc_event_gen

// ### design/sctc_split_capture.sv
// Timer core with auto-reload and split capture modes and its special-function registers
`timescale 1ns/1ps
// Overview of operation
// (RULE_01) With capture and split both on, the two count bytes act as separate 8-bit counters.
// (RULE_02) In split capture each count byte increments alone and wraps from ff to 00 by itself.
// (RULE_03) Each capture event in split capture copies high count to high reload, low to low.
// (RULE_04) Each capture event raises the timer interrupt when the timer interrupt is enabled.
// (RULE_05) Capture enable at one turns auto-reload counting into one of the capture modes.
// (RULE_06) The source select picks start-of-frame or the slow oscillator falling edge as trigger.
// (RULE_07) The high and low overflow flags set when their count byte wraps from ff to 00.
// (RULE_08) Hardware never clears the overflow flags; software clears them.
// (RULE_09) With low byte interrupt enable and timer interrupts on, a low overflow interrupts too.
module sctc_split_capture (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Special-function register port
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // Event and count sources
   input wire logic sof_pulse,
   input wire logic slow_oscillator,
   input wire logic ext_tick,
   // Per-byte system clock selects
   input wire logic high_sysclk_sel,
   input wire logic low_sysclk_sel,
   // Interrupt
   input wire logic irq_global_en,
   output logic timer_irq
);
   sctc_pkg::sctc_state_s s_q, s_d;
   sctc_evt_if evt ();
   logic split, run, ce, tick_l, tick_h, en_l, en_h, inc_h;
   logic low_wrap, high_wrap, cap, wr_ctl, wr_rll, wr_rlh, wr_cl, wr_ch;

   function automatic logic wraps(input logic en, input logic [7:0] v);
      return en & (v == sctc_pkg::BYTE_MAX);
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
      return sfr_wr & (a == target);
   endfunction

   sctc_event_gen u_evt (
      .clk(clk),
      .nrst(nrst),
      .sof_pulse(sof_pulse),
      .slow_oscillator(slow_oscillator),
      .evt(evt)
   );

   assign evt.src_sel = s_q.ctl[sctc_pkg::BIT_SRC_SEL];
   assign split = s_q.ctl[sctc_pkg::BIT_SPLIT];
   assign run = s_q.ctl[sctc_pkg::BIT_RUN];
   assign ce = s_q.ctl[sctc_pkg::BIT_CAPTURE_EN];
   assign wr_ctl = hit(sfr_addr, sctc_pkg::ADDR_CTRL);
   assign wr_rll = hit(sfr_addr, sctc_pkg::ADDR_RELOAD_LOW);
   assign wr_rlh = hit(sfr_addr, sctc_pkg::ADDR_RELOAD_HIGH);
   assign wr_cl = hit(sfr_addr, sctc_pkg::ADDR_COUNT_LOW);
   assign wr_ch = hit(sfr_addr, sctc_pkg::ADDR_COUNT_HIGH);

   // Count tick per byte from sysclk, sysclk/12 or the undivided external tick
   assign tick_l = low_sysclk_sel |
      (s_q.ctl[sctc_pkg::BIT_EXT_CLK] ? ext_tick : evt.tick12);
   assign tick_h = high_sysclk_sel |
      (s_q.ctl[sctc_pkg::BIT_EXT_CLK] ? ext_tick : evt.tick12);
   // Split: low byte always runs, run bit gates high byte only
   assign en_l = tick_l & (split | run);
   assign en_h = split ? (tick_h & run) : en_l; // [RULE_01]
   assign low_wrap = wraps(en_l, s_q.cntl);
   assign inc_h = split ? en_h : low_wrap; // [RULE_01] [RULE_02]
   assign high_wrap = wraps(inc_h, s_q.cnth);
   assign cap = ce & evt.cap_event; // [RULE_05]

   always_comb begin
      s_d = s_q;
      if (wr_ctl) begin
         s_d.ctl = sfr_wdata; // [RULE_08]
      end
      // Hardware sets after the write so a same-cycle clear loses
      if (high_wrap | cap) begin
         s_d.ctl[sctc_pkg::BIT_HIGH_OVF] = 1'b1; // [RULE_07] [RULE_04]
      end
      if (low_wrap) begin
         s_d.ctl[sctc_pkg::BIT_LOW_OVF] = 1'b1; // [RULE_07]
      end
      if (wr_rll) begin
         s_d.rll = sfr_wdata;
      end
      if (wr_rlh) begin
         s_d.rlh = sfr_wdata;
      end
      if (cap) begin
         s_d.rll = s_q.cntl; // [RULE_03]
         s_d.rlh = s_q.cnth; // [RULE_03]
      end
      if (en_l) begin
         s_d.cntl = s_q.cntl + 8'h01; // [RULE_02]
      end
      if (inc_h) begin
         s_d.cnth = s_q.cnth + 8'h01; // [RULE_02]
      end
      // Auto-reload only when capture is off
      if (!ce) begin
         if (split ? low_wrap : high_wrap) begin
            s_d.cntl = s_q.rll; // [RULE_05]
         end
         if (high_wrap) begin
            s_d.cnth = s_q.rlh;
         end
      end
      if (wr_cl) begin
         s_d.cntl = sfr_wdata;
      end
      if (wr_ch) begin
         s_d.cnth = sfr_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         s_q.ctl <= sctc_pkg::CTRL_RESET;
         s_q.rll <= sctc_pkg::BYTE_RESET;
         s_q.rlh <= sctc_pkg::BYTE_RESET;
         s_q.cntl <= sctc_pkg::BYTE_RESET;
         s_q.cnth <= sctc_pkg::BYTE_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   always_comb begin
      case (sfr_addr)
         sctc_pkg::ADDR_CTRL: sfr_rdata = s_q.ctl;
         sctc_pkg::ADDR_RELOAD_LOW: sfr_rdata = s_q.rll;
         sctc_pkg::ADDR_RELOAD_HIGH: sfr_rdata = s_q.rlh;
         sctc_pkg::ADDR_COUNT_LOW: sfr_rdata = s_q.cntl;
         sctc_pkg::ADDR_COUNT_HIGH: sfr_rdata = s_q.cnth;
         default: sfr_rdata = 8'h00;
      endcase
   end

   // Flags persist until software clears them
   assign timer_irq = irq_global_en & (s_q.ctl[sctc_pkg::BIT_HIGH_OVF] |
      (s_q.ctl[sctc_pkg::BIT_LOW_OVF] & s_q.ctl[sctc_pkg::BIT_LOW_IRQ_EN])); // [RULE_04] [RULE_09]

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   split_low_wrap_a: assert property ( // [RULE_02]
      (ce && split && low_wrap && !wr_cl) |=> (s_q.cntl == 8'h00))
      else $error("split low byte did not wrap to zero");
   split_high_hold_a: assert property ( // [RULE_01]
      (ce && split && en_l && !en_h && !wr_ch) |=> $stable(s_q.cnth))
      else $error("high byte moved with low byte in split capture");
   capture_copy_a: assert property ( // [RULE_03]
      cap |=> (s_q.rll == $past(s_q.cntl)) && (s_q.rlh == $past(s_q.cnth)))
      else $error("capture did not copy count bytes");
   capture_irq_a: assert property ( // [RULE_04]
      (cap && irq_global_en) |=> (timer_irq || !irq_global_en || wr_ctl))
      else $error("capture raised no interrupt");
   reload_mode_a: assert property ( // [RULE_05]
      (!ce && !wr_rll && !wr_rlh) |=> $stable(s_q.rll) && $stable(s_q.rlh))
      else $error("reload bytes changed outside capture mode");
   sof_source_a: assert property ( // [RULE_06]
      (ce && !evt.src_sel && sof_pulse && !evt.osc_fall) |=>
         (s_q.rlh == $past(s_q.cnth)))
      else $error("start-of-frame did not trigger capture");
   low_flag_set_a: assert property ( // [RULE_07]
      low_wrap |=> s_q.ctl[sctc_pkg::BIT_LOW_OVF])
      else $error("low overflow flag not set on wrap");
   flag_hold_a: assert property ( // [RULE_08]
      (s_q.ctl[sctc_pkg::BIT_HIGH_OVF] && !wr_ctl) |=> s_q.ctl[sctc_pkg::BIT_HIGH_OVF])
      else $error("high overflow flag cleared by hardware");
   low_irq_a: assert property ( // [RULE_09]
      (s_q.ctl[sctc_pkg::BIT_LOW_OVF] && s_q.ctl[sctc_pkg::BIT_LOW_IRQ_EN] && irq_global_en)
         |-> timer_irq)
      else $error("low overflow did not interrupt");

   // Flag, source and interrupt checks
   high_flag_set_a: assert property ( // [RULE_07]
      high_wrap |=> s_q.ctl[sctc_pkg::BIT_HIGH_OVF])
      else $error("high overflow flag not set on wrap");
   capture_flag_a: assert property ( // [RULE_04]
      cap |=> s_q.ctl[sctc_pkg::BIT_HIGH_OVF])
      else $error("capture did not set the interrupt flag");
   low_flag_hold_a: assert property ( // [RULE_08]
      (s_q.ctl[sctc_pkg::BIT_LOW_OVF] && !wr_ctl) |=> s_q.ctl[sctc_pkg::BIT_LOW_OVF])
      else $error("low overflow flag cleared by hardware");
   sof_low_copy_a: assert property ( // [RULE_06]
      (ce && !evt.src_sel && sof_pulse) |=> (s_q.rll == $past(s_q.cntl)))
      else $error("start-of-frame did not capture low byte");
   osc_source_a: assert property ( // [RULE_06]
      (ce && evt.src_sel && evt.osc_fall) |=> (s_q.rlh == $past(s_q.cnth)))
      else $error("slow oscillator fall did not trigger capture");
   sof_ignored_a: assert property ( // [RULE_06]
      (ce && evt.src_sel && sof_pulse && !evt.osc_fall && !wr_rll) |=> $stable(s_q.rll))
      else $error("start-of-frame captured while oscillator selected");
   irq_gate_a: assert property ( // [RULE_04]
      !irq_global_en |-> !timer_irq)
      else $error("interrupt raised while disabled");
   irq_masked_a: assert property ( // [RULE_09]
      (!s_q.ctl[sctc_pkg::BIT_HIGH_OVF] && !s_q.ctl[sctc_pkg::BIT_LOW_IRQ_EN]) |-> !timer_irq)
      else $error("low overflow interrupted while masked");
   low_wrap_irq_a: assert property ( // [RULE_09]
      (low_wrap && s_q.ctl[sctc_pkg::BIT_LOW_IRQ_EN] && !wr_ctl) |=>
         (timer_irq || !irq_global_en))
      else $error("low wrap raised no interrupt");

   // Counting and reload hold checks
   split_high_wrap_a: assert property ( // [RULE_02]
      (ce && split && en_h && (s_q.cnth == sctc_pkg::BYTE_MAX) && !wr_ch) |=>
         (s_q.cnth == 8'h00))
      else $error("split high byte did not wrap to zero");
   low_count_step_a: assert property ( // [RULE_02]
      (ce && split && en_l && !wr_cl) |=> (s_q.cntl == $past(s_q.cntl) + 8'h01))
      else $error("split low byte did not step by one");
   high_count_step_a: assert property ( // [RULE_01]
      (ce && split && en_h && !wr_ch) |=> (s_q.cnth == $past(s_q.cnth) + 8'h01))
      else $error("split high byte did not step on its own tick");
   high_idle_hold_a: assert property ( // [RULE_01]
      (ce && split && !en_h && !wr_ch) |=> $stable(s_q.cnth))
      else $error("split high byte moved without its tick");
   capture_hold_a: assert property ( // [RULE_05]
      (ce && !cap && !wr_rll) |=> $stable(s_q.rll))
      else $error("low reload byte changed without capture");
endmodule // sctc_split_capture

// ### dv/sctc_far_model.sv
// Far-side model: start-of-frame source and slow oscillator
`timescale 1ns/1ps
module sctc_far_model (
   // Clock
   input wire logic clk,
   // Event outputs
   output logic sof_pulse,
   output logic slow_oscillator
);
   initial begin
      sof_pulse = 1'b0;
      slow_oscillator = 1'b1;
   end
   // One-cycle start-of-frame pulse
   task automatic send_sof();
      @(posedge clk) sof_pulse <= 1'b1;
      @(posedge clk) sof_pulse <= 1'b0;
   endtask
   // Low phase long enough for the synchroniser
   task automatic osc_fall();
      @(posedge clk) slow_oscillator <= 1'b0;
      repeat (8) @(posedge clk);
      slow_oscillator <= 1'b1;
   endtask
endmodule // sctc_far_model

// ### dv/testbench.sv
// Self-checking bench for the split capture timer
`timescale 1ns/1ps
module testbench;
   logic clk, nrst, sfr_wr, ext_tick, high_sel, low_sel, irq_en, chk, timer_irq;
   logic sof_pulse, slow_oscillator;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, a, b, got;
   logic [8:0] e;
   logic [8:0] exp_q[$];
   int failures, checked;
   sctc_far_model far (.clk(clk), .sof_pulse(sof_pulse), .slow_oscillator(slow_oscillator));
   sctc_split_capture dut (.clk(clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sof_pulse(sof_pulse),
      .slow_oscillator(slow_oscillator), .ext_tick(ext_tick), .high_sysclk_sel(high_sel),
      .low_sysclk_sel(low_sel), .irq_global_en(irq_en), .timer_irq(timer_irq));
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge clk);
      sfr_addr <= ad;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clk);
      sfr_wr <= 1'b0;
   endtask
   // Bit 8 of a note selects the interrupt line instead of read data
   task automatic expect_val(input logic [7:0] ad, input logic [8:0] n);
      @(posedge clk);
      sfr_addr <= ad;
      chk <= 1'b1;
      exp_q.push_back(n);
      @(posedge clk);
      chk <= 1'b0;
   endtask
   task automatic tick();
      @(posedge clk);
      ext_tick <= 1'b1;
      @(posedge clk);
      ext_tick <= 1'b0;
   endtask
   task automatic done(input string n);
      $display("test %s done", n);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      if (chk) begin
         e = exp_q.pop_front();
         got = e[8] ? {7'h00, timer_irq} : sfr_rdata;
         checked++;
         if (got !== e[7:0]) begin
            failures++;
            $display("mismatch %s at %h expected %h seen %h", e[8] ? "timer_irq" : "sfr_rdata",
               sfr_addr, e[7:0], got);
         end
      end
   end
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      #(25ns * 4000);
      failures++;
      print_verdict();
   end
   initial begin
      {nrst, sfr_wr, ext_tick, high_sel, low_sel, chk} = '0;
      irq_en = 1'b1;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      void'($urandom(32'hdcb4d851));
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i < 6; i++) expect_val(8'hc8 + 8'(i), 9'h000);
      done("reset");
      wr(sctc_pkg::ADDR_CTRL, 8'h1d);
      wr(sctc_pkg::ADDR_COUNT_LOW, 8'h10);
      wr(sctc_pkg::ADDR_COUNT_HIGH, 8'h20);
      tick();
      expect_val(sctc_pkg::ADDR_COUNT_LOW, 9'h011);
      expect_val(sctc_pkg::ADDR_COUNT_HIGH, 9'h021);
      wr(sctc_pkg::ADDR_COUNT_LOW, 8'hff);
      wr(sctc_pkg::ADDR_COUNT_HIGH, 8'hff);
      tick();
      expect_val(sctc_pkg::ADDR_COUNT_LOW, 9'h000);
      expect_val(sctc_pkg::ADDR_COUNT_HIGH, 9'h000);
      expect_val(sctc_pkg::ADDR_CTRL, 9'h0dd);
      expect_val(sctc_pkg::ADDR_CTRL, 9'h101);
      repeat (20) @(posedge clk);
      expect_val(sctc_pkg::ADDR_CTRL, 9'h0dd);
      @(posedge clk);
      high_sel <= 1'b1;
      low_sel <= 1'b1;
      repeat (5) @(posedge clk);
      high_sel <= 1'b0;
      low_sel <= 1'b0;
      expect_val(sctc_pkg::ADDR_COUNT_LOW, 9'h005);
      expect_val(sctc_pkg::ADDR_COUNT_HIGH, 9'h005);
      // Prescaled source, high byte stopped: two prescale periods give two low ticks
      wr(sctc_pkg::ADDR_CTRL, 8'h18);
      wr(sctc_pkg::ADDR_COUNT_LOW, 8'h00);
      repeat (2 * sctc_pkg::PRESCALE_DIV - 1) @(posedge clk);
      expect_val(sctc_pkg::ADDR_COUNT_LOW, 9'h002);
      expect_val(sctc_pkg::ADDR_COUNT_HIGH, 9'h005);
      done("split counting");
      for (int i = 0; i < 4; i++) begin
         a = 8'($urandom);
         b = 8'($urandom);
         irq_en <= 1'(i);
         wr(sctc_pkg::ADDR_CTRL, 8'h1d);
         wr(sctc_pkg::ADDR_COUNT_LOW, a);
         wr(sctc_pkg::ADDR_COUNT_HIGH, b);
         far.send_sof();
         expect_val(sctc_pkg::ADDR_RELOAD_LOW, {1'b0, a});
         expect_val(sctc_pkg::ADDR_RELOAD_HIGH, {1'b0, b});
         expect_val(sctc_pkg::ADDR_CTRL, 9'h09d);
         expect_val(sctc_pkg::ADDR_CTRL, {8'h80, 1'(i)});
      end
      wr(sctc_pkg::ADDR_CTRL, 8'h0d);
      wr(sctc_pkg::ADDR_COUNT_LOW, 8'h5a);
      far.send_sof();
      expect_val(sctc_pkg::ADDR_RELOAD_LOW, {1'b0, a});
      wr(sctc_pkg::ADDR_CTRL, 8'h1f);
      far.send_sof();
      expect_val(sctc_pkg::ADDR_RELOAD_LOW, {1'b0, a});
      far.osc_fall();
      expect_val(sctc_pkg::ADDR_RELOAD_LOW, 9'h05a);
      done("capture");
      irq_en <= 1'b1;
      wr(sctc_pkg::ADDR_CTRL, 8'h1d);
      // Known high byte so its own ticks cannot wrap it here
      wr(sctc_pkg::ADDR_COUNT_HIGH, 8'h00);
      wr(sctc_pkg::ADDR_COUNT_LOW, 8'hff);
      tick();
      expect_val(sctc_pkg::ADDR_CTRL, 9'h05d);
      expect_val(sctc_pkg::ADDR_CTRL, 9'h100);
      wr(sctc_pkg::ADDR_CTRL, 8'h3d);
      wr(sctc_pkg::ADDR_COUNT_LOW, 8'hff);
      tick();
      expect_val(sctc_pkg::ADDR_CTRL, 9'h07d);
      expect_val(sctc_pkg::ADDR_CTRL, 9'h101);
      done("low byte interrupt");
      print_verdict();
   end
endmodule // testbench
